/* src/ovsc_pkg.sv */
// Package of constants and types for the OTG VBUS status and switch control block.
package ovsc_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_IE_RISE = 8'h0D;
    localparam logic [7:0] ADDR_IE_FALL = 8'h10;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h13;
    localparam logic [7:0] ADDR_INT_LATCH = 8'h14;
    localparam logic [7:0] ADDR_OTG_CTRL = 8'h0A;
    localparam logic [7:0] ADDR_IFC_CTRL = 8'h07;
    localparam logic [7:0] ADDR_IO_PWR = 8'h39;
    localparam logic [7:0] ADDR_CARKIT = 8'h19;
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_RXCMD = 8'h3C;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_VBUS_VALID = 1;
    localparam int BIT_SESS_VALID = 2;
    localparam int BIT_SESS_END = 3;
    localparam int BIT_PULLDOWN = 3;
    localparam int BIT_PULLUP = 4;
    localparam int BIT_USE_EXT = 5;
    localparam int BIT_PASS_THRU = 6;
    localparam int BIT_COMPLEMENT = 7;
    localparam int BIT_UART_MODE = 6;
    localparam int BIT_UART_REG_LO = 1;
    localparam int BIT_DP_PULLUP = 4;
    localparam int BIT_DM_PULLUP = 5;
    localparam int BIT_SPK_LEFT = 2;
    localparam int BIT_SPK_RIGHT = 3;
    localparam int BIT_MIC = 4;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_IE_RISE = 8'h1F;
    localparam logic [7:0] RST_IE_FALL = 8'h1F;
    localparam logic [7:0] RST_OTG_CTRL = 8'h06;
    localparam logic [7:0] RST_IFC_CTRL = 8'h00;
    localparam logic [7:0] RST_IO_PWR = 8'h00;
    localparam logic [7:0] RST_CARKIT = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h41;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        OVSC_SRC_COMP = 2'b00,
        OVSC_SRC_ONE = 2'b01,
        OVSC_SRC_ZERO = 2'b10
    } ovsc_vsrc_t;

endpackage : ovsc_pkg

/* src/ovsc_cmp_if.sv */
// Interface carrying comparator states and edge events between modules.
`timescale 1ns/1ps
interface ovsc_cmp_if;
    logic [2:0] level;
    logic [2:0] rise;
    logic [2:0] fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface : ovsc_cmp_if

/* src/ovsc_sync.sv */
// Three-stage synchroniser with agreement filter and edge detection.
`timescale 1ns/1ps
module ovsc_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Raw inputs
    input wire logic [WIDTH-1:0] raw,
    // Filtered outputs
    ovsc_cmp_if.src cmp
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] lvl_reg;
    logic [WIDTH-1:0] lvl_next;
    logic [WIDTH-1:0] agree;

    assign agree = ~(s2_reg ^ s3_reg);
    assign lvl_next = (agree & s3_reg) | (~agree & lvl_reg);

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            lvl_reg <= '0;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end

    assign cmp.level = lvl_reg;
    assign cmp.rise = lvl_next & ~lvl_reg;
    assign cmp.fall = ~lvl_next & lvl_reg;
endmodule : ovsc_sync

/* src/ovsc_top.sv */
// Control and status logic for VBUS comparators, pulsing resistors and cable switches.
`timescale 1ns/1ps

// Notes on behaviour
// - Session-end status goes 0 to 1 when VBUS drops under the end threshold.
// - Session-end enable clear in both edge registers disables it; status reads 0.
// - Session-valid enable clear only masks interrupts; live state stays readable.
// - VBUS-valid enable clear in both registers disables it; status bit 1 reads 0.
// - External VBUS-valid indicator input is treated as constant one.
// - Use-external 0, or pass-through and complement 0, selects internal comparator.
// - Use-external 1: pass-through alone gives 1, complement gives 0.
// - After reset the external indicator logic is off.
// - Discharge resistor follows OTG control bit 3.
// - Charge pull-up resistor follows OTG control bit 4.
// - In UART mode the regulator takes the UART level field.
// - In UART mode line state is not shown on data bits 0 and 1.
// - Weak pull-ups off in reset, then follow their enable bits.
// - Audio switch enables reset to disabled.
// - Reset pin low or core supply absent turns both audio switches on.
// - Otherwise DP follows left enable, DM follows right or microphone.
// - Single-ended receivers off while any audio switch is on.
// - Live states of enabled comparators are readable in the status register.
module ovsc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Comparators and pins
    input wire logic cmp_sess_end,
    input wire logic cmp_sess_valid,
    input wire logic cmp_vbus_valid,
    input wire logic reset_pin_low_active,
    input wire logic core_supply_1v8,
    input wire logic [1:0] line_state,
    // Analog controls
    output logic [2:0] cmp_enable,
    output logic vbus_pulldown_ctl,
    output logic vbus_pullup_ctl,
    output logic [1:0] regulator_level,
    output logic [1:0] data_low_out,
    output logic dp_weak_pullup_en,
    output logic dm_weak_pullup_en,
    output logic dp_audio_switch,
    output logic dm_audio_switch,
    output logic se_receiver_en,
    // Receive command status
    output logic rx_vbus_valid,
    output logic rx_event
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] ie_rise_reg;
    logic [7:0] ie_fall_reg;
    logic [7:0] latch_reg;
    logic [7:0] latch_next;
    logic [7:0] otg_reg;
    logic [7:0] ifc_reg;
    logic [7:0] io_reg;
    logic [7:0] carkit_reg;
    logic [7:0] mode_reg;
    logic [7:0] rdata_next;
    logic [2:0] rst_sync_reg;
    logic rst_pin_reg;
    logic [2:0] sup_sync_reg;
    logic sup_reg;
    logic [2:0] ev_mask;
    logic [2:0] cmp_en;
    logic [2:0] live;
    logic [7:0] status;
    logic [7:0] ev_bits;
    logic ext_vbus_ind;
    logic vbus_sel;
    logic uart_on;
    logic audio_force;
    logic dp_sw;
    logic dm_sw;
    logic [1:0] reg_lvl;
    ovsc_pkg::ovsc_vsrc_t vsrc;

    logic [2:0] rise_en;
    logic [2:0] fall_en;
    logic hit_ie_rise;
    logic hit_ie_fall;
    logic hit_otg;
    logic hit_ifc;
    logic hit_io;
    logic hit_carkit;
    logic hit_mode;
    logic clr_latch;
    logic rst_agree;
    logic sup_agree;
    logic [7:0] rxcmd_view;
    logic [7:0] reg_rdata_next;
    logic [1:0] pulse_next;
    logic [1:0] data_low_next;
    logic dp_weak_next;
    logic dm_weak_next;
    logic se_next;
    logic rx_event_next;

    // ************************************************************
    // Comparator synchroniser
    // ************************************************************
    ovsc_cmp_if cmp_bus ();

    // Comparator order in the vector: 0 vbus valid, 1 session valid, 2 session end.
    ovsc_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .raw({cmp_sess_end, cmp_sess_valid, cmp_vbus_valid}),
        .cmp(cmp_bus.src)
    );

    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off);
        wr_hit = (a == off);
    endfunction : wr_hit

    // Bit position of each comparator in the enable and status registers.
    function automatic int cmp_pos(input int idx);
        case (idx)
            0: cmp_pos = ovsc_pkg::BIT_VBUS_VALID;
            1: cmp_pos = ovsc_pkg::BIT_SESS_VALID;
            default: cmp_pos = ovsc_pkg::BIT_SESS_END;
        endcase
    endfunction : cmp_pos

    // ************************************************************
    // Write decode
    // ************************************************************
    assign hit_ie_rise = reg_wr && wr_hit(reg_addr, ovsc_pkg::ADDR_IE_RISE);
    assign hit_ie_fall = reg_wr && wr_hit(reg_addr, ovsc_pkg::ADDR_IE_FALL);
    assign hit_otg = reg_wr && wr_hit(reg_addr, ovsc_pkg::ADDR_OTG_CTRL);
    assign hit_ifc = reg_wr && wr_hit(reg_addr, ovsc_pkg::ADDR_IFC_CTRL);
    assign hit_io = reg_wr && wr_hit(reg_addr, ovsc_pkg::ADDR_IO_PWR);
    assign hit_carkit = reg_wr && wr_hit(reg_addr, ovsc_pkg::ADDR_CARKIT);
    assign hit_mode = reg_wr && wr_hit(reg_addr, ovsc_pkg::ADDR_MODE);
    assign clr_latch = reg_rd && wr_hit(reg_addr, ovsc_pkg::ADDR_INT_LATCH);

    // ************************************************************
    // Comparator enables and status
    // ************************************************************
    assign cmp_en[0] = ie_rise_reg[ovsc_pkg::BIT_VBUS_VALID]
        | ie_fall_reg[ovsc_pkg::BIT_VBUS_VALID];
    assign cmp_en[1] = 1'b1;
    assign cmp_en[2] = ie_rise_reg[ovsc_pkg::BIT_SESS_END]
        | ie_fall_reg[ovsc_pkg::BIT_SESS_END];
    assign live = cmp_bus.level & cmp_en;

    // ************************************************************
    // Edge events
    // ************************************************************
    for (genvar g = 0; g < 3; g++) begin : g_edge
        assign rise_en[g] = ie_rise_reg[cmp_pos(g)];
        assign fall_en[g] = ie_fall_reg[cmp_pos(g)];
        assign ev_mask[g] = (cmp_bus.rise[g] & rise_en[g])
            | (cmp_bus.fall[g] & fall_en[g]);
    end

    always_comb begin
        status = 8'h00;
        ev_bits = 8'h00;
        for (int i = 0; i < 3; i++) begin
            status[cmp_pos(i)] = live[i];
            ev_bits[cmp_pos(i)] = ev_mask[i];
        end
    end
    // Read clears the latch, but an event in the same cycle survives.
    assign latch_next = (clr_latch ? 8'h00 : latch_reg) | ev_bits;

    // ************************************************************
    // VBUS-valid source selection
    // ************************************************************
    assign ext_vbus_ind = 1'b1;
    always_comb begin
        vsrc = ovsc_pkg::OVSC_SRC_COMP;
        if (ifc_reg[ovsc_pkg::BIT_USE_EXT]) begin
            if (ifc_reg[ovsc_pkg::BIT_COMPLEMENT]) begin
                vsrc = ovsc_pkg::OVSC_SRC_ZERO;
            end else if (otg_reg[ovsc_pkg::BIT_PASS_THRU]) begin
                vsrc = ovsc_pkg::OVSC_SRC_ONE;
            end
        end
    end
    always_comb begin
        case (vsrc)
            ovsc_pkg::OVSC_SRC_COMP: vbus_sel = live[0];
            ovsc_pkg::OVSC_SRC_ONE: vbus_sel = ext_vbus_ind;
            ovsc_pkg::OVSC_SRC_ZERO: vbus_sel = 1'b0;
            default: vbus_sel = live[0];
        endcase
    end
    assign rxcmd_view = {6'h00, vbus_sel, 1'b0};

    // ************************************************************
    // UART, pull-ups and audio switches
    // ************************************************************
    assign uart_on = mode_reg[ovsc_pkg::BIT_UART_MODE];
    assign reg_lvl = uart_on ? io_reg[ovsc_pkg::BIT_UART_REG_LO +: 2] : 2'b00;
    assign audio_force = ~rst_pin_reg | ~sup_reg;
    assign dp_sw = audio_force | carkit_reg[ovsc_pkg::BIT_SPK_LEFT];
    assign dm_sw = audio_force | carkit_reg[ovsc_pkg::BIT_SPK_RIGHT]
        | carkit_reg[ovsc_pkg::BIT_MIC];

    // ************************************************************
    // Read decode
    // ************************************************************
    always_comb begin
        case (reg_addr)
            ovsc_pkg::ADDR_IE_RISE: rdata_next = ie_rise_reg;
            ovsc_pkg::ADDR_IE_FALL: rdata_next = ie_fall_reg;
            ovsc_pkg::ADDR_INT_STATUS: rdata_next = status;
            ovsc_pkg::ADDR_INT_LATCH: rdata_next = latch_reg;
            ovsc_pkg::ADDR_OTG_CTRL: rdata_next = otg_reg;
            ovsc_pkg::ADDR_IFC_CTRL: rdata_next = ifc_reg;
            ovsc_pkg::ADDR_IO_PWR: rdata_next = io_reg;
            ovsc_pkg::ADDR_CARKIT: rdata_next = carkit_reg;
            ovsc_pkg::ADDR_MODE: rdata_next = mode_reg;
            ovsc_pkg::ADDR_RXCMD: rdata_next = rxcmd_view;
            default: rdata_next = 8'h00;
        endcase
    end

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    assign rst_agree = (rst_sync_reg[1] == rst_sync_reg[2]);
    assign sup_agree = (sup_sync_reg[1] == sup_sync_reg[2]);
    always_ff @(posedge clk) begin
        if (srst) begin
            rst_sync_reg <= 3'h0;
            sup_sync_reg <= 3'h0;
            rst_pin_reg <= 1'b0;
            sup_reg <= 1'b0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[1:0], reset_pin_low_active};
            sup_sync_reg <= {sup_sync_reg[1:0], core_supply_1v8};
            if (rst_agree) begin
                rst_pin_reg <= rst_sync_reg[2];
            end
            if (sup_agree) begin
                sup_reg <= sup_sync_reg[2];
            end
        end
    end

    // ************************************************************
    // Register writes
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            ie_rise_reg <= ovsc_pkg::RST_IE_RISE;
            ie_fall_reg <= ovsc_pkg::RST_IE_FALL;
            otg_reg <= ovsc_pkg::RST_OTG_CTRL;
            ifc_reg <= ovsc_pkg::RST_IFC_CTRL;
            io_reg <= ovsc_pkg::RST_IO_PWR;
            carkit_reg <= ovsc_pkg::RST_CARKIT;
            mode_reg <= ovsc_pkg::RST_MODE;
            latch_reg <= 8'h00;
        end else begin
            latch_reg <= latch_next;
            if (reg_wr) begin
                if (hit_ie_rise) begin
                    ie_rise_reg <= reg_wdata;
                end
                if (hit_ie_fall) begin
                    ie_fall_reg <= reg_wdata;
                end
                if (hit_otg) begin
                    otg_reg <= reg_wdata;
                end
                if (hit_ifc) begin
                    ifc_reg <= reg_wdata;
                end
                if (hit_io) begin
                    io_reg <= reg_wdata;
                end
                if (hit_carkit) begin
                    carkit_reg <= reg_wdata;
                end
                if (hit_mode) begin
                    mode_reg <= reg_wdata;
                end
            end
        end
    end

    // ************************************************************
    // Output next values
    // ************************************************************
    assign reg_rdata_next = reg_rd ? rdata_next : 8'h00;
    assign pulse_next = {otg_reg[ovsc_pkg::BIT_PULLUP],
        otg_reg[ovsc_pkg::BIT_PULLDOWN]};
    assign data_low_next = uart_on ? 2'b00 : line_state;
    assign dp_weak_next = rst_pin_reg & io_reg[ovsc_pkg::BIT_DP_PULLUP];
    assign dm_weak_next = rst_pin_reg & io_reg[ovsc_pkg::BIT_DM_PULLUP];
    assign se_next = ~(dp_sw | dm_sw);
    assign rx_event_next = |ev_mask;

    // ************************************************************
    // Registered outputs
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
            cmp_enable <= 3'h0;
            vbus_pulldown_ctl <= 1'b0;
            vbus_pullup_ctl <= 1'b0;
            regulator_level <= 2'b00;
            data_low_out <= 2'b00;
            dp_weak_pullup_en <= 1'b0;
            dm_weak_pullup_en <= 1'b0;
            dp_audio_switch <= 1'b1;
            dm_audio_switch <= 1'b1;
            se_receiver_en <= 1'b0;
            rx_vbus_valid <= 1'b0;
            rx_event <= 1'b0;
        end else begin
            reg_rdata <= reg_rdata_next;
            cmp_enable <= cmp_en;
            vbus_pulldown_ctl <= pulse_next[0];
            vbus_pullup_ctl <= pulse_next[1];
            regulator_level <= reg_lvl;
            data_low_out <= data_low_next;
            dp_weak_pullup_en <= dp_weak_next;
            dm_weak_pullup_en <= dm_weak_next;
            dp_audio_switch <= dp_sw;
            dm_audio_switch <= dm_sw;
            se_receiver_en <= se_next;
            rx_vbus_valid <= vbus_sel;
            rx_event <= rx_event_next;
        end
    end

endmodule : ovsc_top

/* dv/ovsc_vbus_model.sv */
// Behavioural model of the VBUS comparators seen by the block.
`timescale 1ns/1ps
module ovsc_vbus_model #(
    parameter int SV_MV = 2000,
    parameter int VV_MV = 4400
) (
    // VBUS level in millivolts
    input wire integer vbus_mv,
    // Comparator levels
    output logic cmp_sess_end,
    output logic cmp_sess_valid,
    output logic cmp_vbus_valid
);
    assign cmp_sess_end = vbus_mv < 500;
    assign cmp_sess_valid = vbus_mv > SV_MV;
    assign cmp_vbus_valid = vbus_mv > VV_MV;
endmodule : ovsc_vbus_model

/* dv/ovsc_properties.sv */
// Port checker for the VBUS status and switch block.
`timescale 1ns/1ps
module ovsc_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins and controls
    input wire logic reset_pin_low_active,
    input wire logic core_supply_1v8,
    input wire logic [2:0] cmp_enable,
    input wire logic vbus_pulldown_ctl,
    input wire logic vbus_pullup_ctl,
    input wire logic dp_weak_pullup_en,
    input wire logic dm_weak_pullup_en,
    input wire logic dp_audio_switch,
    input wire logic dm_audio_switch,
    input wire logic se_receiver_en
);
    logic [1:0] otg_bits_reg;
    wire otg_wr = reg_wr && reg_addr == ovsc_pkg::ADDR_OTG_CTRL;
    wire st_rd = reg_rd && reg_addr == ovsc_pkg::ADDR_INT_STATUS;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    always_ff @(posedge clk) begin
        if (otg_wr) begin
            otg_bits_reg <= reg_wdata[4:3];
        end
    end
    a_pulldown_follow: assert property (otg_wr ##1 !otg_wr |=>
        vbus_pulldown_ctl == otg_bits_reg[0]) else $error("pulldown wrong");
    a_pullup_follow: assert property (otg_wr ##1 !otg_wr |=>
        vbus_pullup_ctl == otg_bits_reg[1]) else $error("pullup wrong");
    a_audio_forced_on: assert property ((!reset_pin_low_active || !core_supply_1v8)[*6]
        |-> dp_audio_switch && dm_audio_switch) else $error("switches not forced");
    a_weak_pullup_gated: assert property ((!reset_pin_low_active)[*6]
        |-> !dp_weak_pullup_en && !dm_weak_pullup_en) else $error("weak pullup on");
    a_se_rx_off: assert property ((dp_audio_switch || dm_audio_switch)[*2]
        |-> !se_receiver_en) else $error("receiver on");
    a_vbus_status_off: assert property (st_rd && !cmp_enable[0] |=>
        !reg_rdata[ovsc_pkg::BIT_VBUS_VALID]) else $error("vbus bit set");
    a_end_status_off: assert property (st_rd && !cmp_enable[2] |=>
        !reg_rdata[ovsc_pkg::BIT_SESS_END]) else $error("end bit set");
    a_sess_valid_live: assert property (!$past(srst) |-> cmp_enable[1])
        else $error("session comparator off");
endmodule : ovsc_properties

/* dv/ovsc_top_tb_top.sv */
// Self-checking bench for the VBUS status and switch block.
`timescale 1ns/1ps
module ovsc_top_tb_top;
    logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, reset_pin_low_active = 1;
    logic core_supply_1v8 = 1, vbus_pulldown_ctl, vbus_pullup_ctl, dp_weak_pullup_en;
    logic dm_weak_pullup_en, dp_audio_switch, dm_audio_switch, se_receiver_en;
    logic cmp_sess_end, cmp_sess_valid, cmp_vbus_valid, rx_vbus_valid, rx_event;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val, o, k, io;
    logic [1:0] line_state = 2'h0, regulator_level, data_low_out;
    logic [2:0] cmp_enable;
    logic u, m, c;
    int vbus_mv = 5000, mismatches = 0, total_checks = 0, ev_cnt = 0;
    int vt[3] = '{5000, 3000, 200};
    ovsc_top u_ovsc_top (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .cmp_sess_end, .cmp_sess_valid, .cmp_vbus_valid, .reset_pin_low_active,
        .core_supply_1v8, .line_state, .cmp_enable, .vbus_pulldown_ctl, .vbus_pullup_ctl,
        .regulator_level, .data_low_out, .dp_weak_pullup_en, .dm_weak_pullup_en,
        .dp_audio_switch, .dm_audio_switch, .se_receiver_en, .rx_vbus_valid, .rx_event);
    ovsc_vbus_model u_ovsc_vbus_model (.vbus_mv, .cmp_sess_end, .cmp_sess_valid,
        .cmp_vbus_valid);
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 0;
        #1 rd_val = reg_rdata;
    endtask : rd
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    function automatic logic vsel(logic use_x, logic pass, logic comp, logic cv);
        if (!use_x || (!pass && !comp)) return cv;
        return !comp;
    endfunction : vsel
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    // ****************************************
    // Stimulus
    // ****************************************
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rx_event === 1'b1) ev_cnt++;
    end
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
    initial begin
        void'($urandom(4));
        repeat (5) @(posedge clk);
        srst <= 0;
        tick(8);
        rd(ovsc_pkg::ADDR_IE_RISE);
        chk(rd_val, ovsc_pkg::RST_IE_RISE);
        rd(ovsc_pkg::ADDR_CARKIT);
        chk(rd_val, 8'h00);
        chk(8'({dp_audio_switch, dm_audio_switch, se_receiver_en, rx_vbus_valid}), 8'h03);
        $display("test reset done");
        foreach (vt[i]) for (int e = 0; e < 2; e++) begin
            wr(ovsc_pkg::ADDR_IE_RISE, e ? 8'h00 : 8'h1F);
            wr(ovsc_pkg::ADDR_IE_FALL, e ? 8'h00 : 8'h1F);
            vbus_mv <= vt[i];
            tick(8);
            rd(ovsc_pkg::ADDR_INT_STATUS);
            chk(rd_val & 8'h0E, 8'({vt[i] < 500 && e == 0, vt[i] > 2000,
                vt[i] > 4400 && e == 0, 1'b0}));
            chk(8'(cmp_enable), e ? 8'h02 : 8'h07);
        end
        wr(ovsc_pkg::ADDR_IE_RISE, 8'h1F);
        wr(ovsc_pkg::ADDR_IE_FALL, 8'h1F);
        $display("test comparators done");
        for (int n = 0; n < 24; n++) begin
            o = 8'($urandom);
            k = 8'($urandom) & 8'h1C;
            io = 8'($urandom) & 8'h36;
            {u, m, c} = 3'($urandom);
            wr(ovsc_pkg::ADDR_OTG_CTRL, o);
            wr(ovsc_pkg::ADDR_IFC_CTRL, {c, 1'b0, u, 5'h00});
            wr(ovsc_pkg::ADDR_IO_PWR, io);
            wr(ovsc_pkg::ADDR_CARKIT, k);
            wr(ovsc_pkg::ADDR_MODE, {1'b0, m, 6'h01});
            line_state <= 2'($urandom);
            vbus_mv <= vt[$urandom_range(1, 0)];
            tick(8);
            chk(8'({vbus_pullup_ctl, vbus_pulldown_ctl}), 8'(o[4:3]));
            chk(8'(rx_vbus_valid), 8'(vsel(u, o[6], c, vbus_mv > 4400)));
            chk(8'(regulator_level), m ? 8'(io[2:1]) : 8'h00);
            chk(8'(data_low_out), m ? 8'h00 : 8'(line_state));
            chk(8'({dp_weak_pullup_en, dm_weak_pullup_en}), 8'({io[4], io[5]}));
            chk(8'({dp_audio_switch, dm_audio_switch}), 8'({k[2], k[3] | k[4]}));
            chk(8'(se_receiver_en), 8'(k[4:2] == 3'h0));
        end
        $display("test random controls done");
        wr(ovsc_pkg::ADDR_CARKIT, 8'h00);
        wr(ovsc_pkg::ADDR_IO_PWR, 8'h30);
        for (int p = 0; p < 2; p++) begin
            reset_pin_low_active <= p[0];
            core_supply_1v8 <= !p[0];
            tick(8);
            chk(8'({dp_audio_switch, dm_audio_switch, se_receiver_en}), 8'h06);
            chk(8'({dp_weak_pullup_en, dm_weak_pullup_en}), p ? 8'h03 : 8'h00);
        end
        reset_pin_low_active <= 1;
        core_supply_1v8 <= 1;
        vbus_mv <= 3000;
        tick(10);
        $display("test pins done");
        wr(ovsc_pkg::ADDR_IE_RISE, 8'h04);
        wr(ovsc_pkg::ADDR_IE_FALL, 8'h00);
        tick(2);
        rd(ovsc_pkg::ADDR_INT_LATCH);
        ev_cnt = 0;
        vbus_mv <= 1000;
        tick(10);
        chk(8'(ev_cnt), 8'h00);
        vbus_mv <= 3000;
        tick(10);
        chk(8'(ev_cnt), 8'h01);
        rd(ovsc_pkg::ADDR_INT_LATCH);
        chk(rd_val, 8'h04);
        rd(8'hFF);
        chk(rd_val, 8'h00);
        $display("test events done");
        end_sim();
    end
endmodule : ovsc_top_tb_top
bind ovsc_top ovsc_properties u_ovsc_properties (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .reset_pin_low_active, .core_supply_1v8, .cmp_enable,
    .vbus_pulldown_ctl, .vbus_pullup_ctl, .dp_weak_pullup_en, .dm_weak_pullup_en,
    .dp_audio_switch, .dm_audio_switch, .se_receiver_en);
